// file: src/atto_pkg.sv
package atto_pkg;

  // Bus and storage widths
  localparam int unsigned ATTO_ADDR_W = 12;
  localparam int unsigned ATTO_DATA_W = 32;
  localparam int unsigned ATTO_STRB_W = 4;
  localparam int unsigned ATTO_IDX_W = 10;
  localparam int unsigned ATTO_TRIM_W = 16;
  localparam int unsigned ATTO_TIM_W = 8;
  localparam int unsigned ATTO_OFS_W = 12;
  localparam int unsigned ATTO_NUM_TRIM = 6;

  // Register indices; byte address is four times the index
  localparam logic [9:0] ATTO_IDX_A_SGL_B_TIM = 10'h31A;
  localparam logic [9:0] ATTO_IDX_B_SGL_B_TIM = 10'h31B;
  localparam logic [9:0] ATTO_IDX_A_DUAL_A_OFS = 10'h344;
  localparam logic [9:0] ATTO_IDX_A_DUAL_B_OFS = 10'h346;
  localparam logic [9:0] ATTO_IDX_A_SGL_A_OFS = 10'h348;
  localparam logic [9:0] ATTO_IDX_A_SGL_B_OFS = 10'h34A;
  localparam logic [9:0] ATTO_IDX_CTRL = 10'h3F0;
  localparam logic [9:0] ATTO_IDX_STATUS = 10'h3F1;

  // Storage slots, in the order of the index table below
  localparam int unsigned ATTO_SLOT_A_SGL_B_TIM = 0;
  localparam int unsigned ATTO_SLOT_B_SGL_B_TIM = 1;
  localparam int unsigned ATTO_SLOT_A_DUAL_A_OFS = 2;
  localparam int unsigned ATTO_SLOT_A_DUAL_B_OFS = 3;
  localparam int unsigned ATTO_SLOT_A_SGL_A_OFS = 4;
  localparam int unsigned ATTO_SLOT_A_SGL_B_OFS = 5;

  localparam logic [9:0] ATTO_TRIM_IDX [ATTO_NUM_TRIM] = '{
    ATTO_IDX_A_SGL_B_TIM, ATTO_IDX_B_SGL_B_TIM, ATTO_IDX_A_DUAL_A_OFS,
    ATTO_IDX_A_DUAL_B_OFS, ATTO_IDX_A_SGL_A_OFS, ATTO_IDX_A_SGL_B_OFS};

  // Implemented bits: timing trims are 8 bits, offset trims 16 bits
  localparam logic [15:0] ATTO_TIM_MASK = 16'h00FF;
  localparam logic [15:0] ATTO_OFS_MASK = 16'hFFFF;
  localparam logic [15:0] ATTO_TRIM_RESET = 16'h0000;

  // Control and status fields
  localparam int unsigned ATTO_CTRL_SINGLE_BIT = 0;
  localparam int unsigned ATTO_CTRL_FGCAL_BIT = 1;
  localparam int unsigned ATTO_CTRL_RELOAD_BIT = 2;
  localparam int unsigned ATTO_ST_LOADED_BIT = 0;
  localparam int unsigned ATTO_ST_ATIM_BIT = 1;
  localparam int unsigned ATTO_ST_BTIM_BIT = 2;
  localparam int unsigned ATTO_ST_AOFS_BIT = 3;
  localparam int unsigned ATTO_ST_SEL_LSB = 4;
  localparam logic [31:0] ATTO_ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    ATTO_SEL_DUAL_A = 2'b00,
    ATTO_SEL_DUAL_B = 2'b01,
    ATTO_SEL_SGL_A = 2'b10,
    ATTO_SEL_SGL_B = 2'b11
  } atto_ofs_sel_t;

  typedef struct packed {
    logic single_mode;
    logic fg_cal;
  } atto_mode_t;

  typedef struct packed {
    logic a_in_b;
    logic a_phase90;
    logic b_in_b;
  } atto_sample_t;

  typedef struct packed {
    logic [7:0] a_sgl_b_tim;
    logic [7:0] b_sgl_b_tim;
    logic [11:0] a_dual_a_ofs;
    logic [11:0] a_dual_b_ofs;
    logic [11:0] a_sgl_a_ofs;
    logic [11:0] a_sgl_b_ofs;
  } atto_fuse_t;

  typedef struct packed {
    logic a_tim_en;
    logic [7:0] a_tim;
    logic b_tim_en;
    logic [7:0] b_tim;
    logic a_ofs_en;
    logic [11:0] a_ofs;
  } atto_trim_out_t;

endpackage

// file: src/atto_trim_reg.sv
`timescale 1ns/1ps
`default_nettype none
module atto_trim_reg
  import atto_pkg::*;
#(
  parameter logic [15:0] MASK = ATTO_OFS_MASK
) (
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Async reset, active high
  input wire logic wr_in, // Bus write strobe
  input wire logic [1:0] strb_in, // Byte lanes of the write
  input wire logic [15:0] wdata_in, // Write data
  input wire logic load_in, // Fuse load strobe
  input wire logic [15:0] fuse_in, // Fuse default value
  output logic [15:0] q_out // Stored value
);

  logic [15:0] next_q;

  // Merge the enabled byte lanes; unimplemented bits stay zero
  always_comb begin
    next_q[7:0] = strb_in[0] ? wdata_in[7:0] : q_out[7:0];
    next_q[15:8] = strb_in[1] ? wdata_in[15:8] : q_out[15:8];
    next_q = next_q & MASK;
  end

  // Software write wins over a fuse load in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_out <= ATTO_TRIM_RESET;
    end else if (wr_in) begin
      q_out <= next_q;
    end else if (load_in) begin
      q_out <= fuse_in & MASK;
    end
  end

endmodule
`default_nettype wire

// file: src/atto_fuse_load.sv
`timescale 1ns/1ps
`default_nettype none
module atto_fuse_load
  import atto_pkg::*;
(
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Async reset, active high
  input wire logic valid_pin_in, // Fuse data valid from fuse block
  input wire atto_fuse_t data_pin_in, // Fuse values from fuse block
  input wire logic reload_in, // Software reload pulse
  output logic load_out, // One-cycle load strobe
  output atto_fuse_t data_out, // Synchronised fuse values
  output logic loaded_out // Set once a load happened
);

  logic valid_meta;
  logic valid_sync;
  logic valid_late;
  logic valid_prev;
  atto_fuse_t data_meta;

  // Two-stage synchronisers; valid is held back one more stage so the
  // data word has settled for a full cycle before it is loaded
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_meta <= 1'b0;
      valid_sync <= 1'b0;
      valid_late <= 1'b0;
      valid_prev <= 1'b0;
      data_meta <= '0;
      data_out <= '0;
    end else begin
      valid_meta <= valid_pin_in;
      valid_sync <= valid_meta;
      valid_late <= valid_sync;
      valid_prev <= valid_late;
      data_meta <= data_pin_in;
      data_out <= data_meta;
    end
  end

  // Load on the rising edge of valid, or on request while valid
  assign load_out = valid_late & (~valid_prev | reload_in);

  // Sticky indication for software
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      loaded_out <= 1'b0;
    end else if (load_out) begin
      loaded_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: src/atto_regs.sv
// Contract
// - Core A single mode input B timing trim
// - Core B single mode input B timing trim
// - Core A dual mode input A offset
// - Core A dual mode input B offset
// - Core A single mode input A offset
// - Core A input B 90 degree offset
// - Offset trims 16 bits, upper four reserved
// - Defaults loaded from fuses, software may overwrite
// - Timing trims adjust each core's sampling instant
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module atto_regs
  import atto_pkg::*;
(
  input wire logic MCLK_IN, // Core clock, 100 MHz
  input wire logic RESET_IN, // Async reset, active high
  input wire logic PSEL_IN, // APB select
  input wire logic PENABLE_IN, // APB enable
  input wire logic PWRITE_IN, // APB direction, high for write
  input wire logic [11:0] PADDR_IN, // APB byte address
  input wire logic [31:0] PWDATA_IN, // APB write data
  input wire logic [3:0] PSTRB_IN, // APB write byte strobes
  output logic [31:0] PRDATA_OUT, // APB read data
  output logic PREADY_OUT, // APB ready
  output logic PSLVERR_OUT, // APB error on unmapped address
  input wire logic FUSE_VALID_IN, // Fuse values valid, async
  input wire atto_fuse_t FUSE_DATA_IN, // Fuse default values, async
  input wire atto_sample_t SAMPLE_IN, // Converter sampling state
  output atto_trim_out_t TRIM_OUT // Trims applied to the cores
);

  logic [15:0] trim_q [ATTO_NUM_TRIM];
  logic [15:0] fuse_word [ATTO_NUM_TRIM];
  logic [ATTO_NUM_TRIM-1:0] trim_hit;
  logic [ATTO_NUM_TRIM-1:0] trim_wr;
  logic [9:0] idx;
  logic aligned;
  logic hit_ctrl;
  logic hit_status;
  logic mapped;
  logic setup;
  logic access;
  logic wr_access;
  logic err_q;
  logic [31:0] next_rdata;
  atto_mode_t mode;
  logic reload;
  logic fuse_load;
  logic fuse_loaded;
  atto_fuse_t fuse_sync;
  logic next_a_tim_en;
  logic next_b_tim_en;
  logic next_a_ofs_en;
  atto_ofs_sel_t next_sel;
  atto_ofs_sel_t sel_q;

  // Address decode; registers sit on aligned words only
  assign idx = PADDR_IN[11:2];
  assign aligned = (PADDR_IN[1:0] == 2'b00);
  assign hit_ctrl = aligned & (idx == ATTO_IDX_CTRL);
  assign hit_status = aligned & (idx == ATTO_IDX_STATUS);
  assign mapped = (|trim_hit) | hit_ctrl | hit_status;
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign access = PSEL_IN & PENABLE_IN;
  assign wr_access = access & PWRITE_IN & ~err_q;

  // Zero wait states: every access phase completes at its first edge
  assign PREADY_OUT = access;
  assign PSLVERR_OUT = access & err_q;

  // Fuse values mapped onto the storage slots
  assign fuse_word[ATTO_SLOT_A_SGL_B_TIM] = {8'h00, fuse_sync.a_sgl_b_tim};
  assign fuse_word[ATTO_SLOT_B_SGL_B_TIM] = {8'h00, fuse_sync.b_sgl_b_tim};
  assign fuse_word[ATTO_SLOT_A_DUAL_A_OFS] = {4'h0, fuse_sync.a_dual_a_ofs};
  assign fuse_word[ATTO_SLOT_A_DUAL_B_OFS] = {4'h0, fuse_sync.a_dual_b_ofs};
  assign fuse_word[ATTO_SLOT_A_SGL_A_OFS] = {4'h0, fuse_sync.a_sgl_a_ofs};
  assign fuse_word[ATTO_SLOT_A_SGL_B_OFS] = {4'h0, fuse_sync.a_sgl_b_ofs};

  // Fuse defaults arrive from another domain, hence the synchroniser
  atto_fuse_load u_fuse (
    .clk_in(MCLK_IN),
    .rst_in(RESET_IN),
    .valid_pin_in(FUSE_VALID_IN),
    .data_pin_in(FUSE_DATA_IN),
    .reload_in(reload),
    .load_out(fuse_load),
    .data_out(fuse_sync),
    .loaded_out(fuse_loaded)
  );

  // One storage register per trim, sized by its implemented bits
  genvar g;
  generate
    for (g = 0; g < ATTO_NUM_TRIM; g++) begin : g_trim
      localparam logic [15:0] MASK_G =
        (g < ATTO_SLOT_A_DUAL_A_OFS) ? ATTO_TIM_MASK
          : ATTO_OFS_MASK;
      assign trim_hit[g] = aligned & (idx == ATTO_TRIM_IDX[g]);
      assign trim_wr[g] = wr_access & trim_hit[g];
      atto_trim_reg #(
        .MASK(MASK_G)
      ) u_reg (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .wr_in(trim_wr[g]),
        .strb_in(PSTRB_IN[1:0]),
        .wdata_in(PWDATA_IN[15:0]),
        .load_in(fuse_load),
        .fuse_in(fuse_word[g]),
        .q_out(trim_q[g])
      );
    end
  endgenerate

  // Control register: mode, calibration enable, fuse reload request
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      mode <= '0;
    end else if (wr_access & hit_ctrl & PSTRB_IN[0]) begin
      mode.single_mode <= PWDATA_IN[ATTO_CTRL_SINGLE_BIT];
      mode.fg_cal <= PWDATA_IN[ATTO_CTRL_FGCAL_BIT];
    end
  end

  // Reload is a self-clearing pulse; it always reads back as zero
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      reload <= 1'b0;
    end else begin
      reload <= wr_access & hit_ctrl & PSTRB_IN[0]
        & PWDATA_IN[ATTO_CTRL_RELOAD_BIT];
    end
  end

  // Read data for the addressed register; unused upper bits read zero
  always_comb begin
    next_rdata = ATTO_ZERO_WORD;
    for (int i = 0; i < ATTO_NUM_TRIM; i++) begin
      if (trim_hit[i]) begin
        next_rdata = {16'h0000, trim_q[i]};
      end
    end
    if (hit_ctrl) begin
      next_rdata[ATTO_CTRL_SINGLE_BIT] = mode.single_mode;
      next_rdata[ATTO_CTRL_FGCAL_BIT] = mode.fg_cal;
    end
    if (hit_status) begin
      next_rdata[ATTO_ST_LOADED_BIT] = fuse_loaded;
      next_rdata[ATTO_ST_ATIM_BIT] = TRIM_OUT.a_tim_en;
      next_rdata[ATTO_ST_BTIM_BIT] = TRIM_OUT.b_tim_en;
      next_rdata[ATTO_ST_AOFS_BIT] = TRIM_OUT.a_ofs_en;
      next_rdata[ATTO_ST_SEL_LSB +: 2] = sel_q;
    end
  end

  // Read data and error captured in the setup phase, shown in access
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT <= ATTO_ZERO_WORD;
      err_q <= 1'b0;
    end else if (setup) begin
      PRDATA_OUT <= PWRITE_IN ? ATTO_ZERO_WORD : next_rdata;
      err_q <= ~mapped;
    end
  end

  // Which trims the current mode and sampling state select
  always_comb begin
    next_a_tim_en = mode.single_mode & mode.fg_cal
      & SAMPLE_IN.a_in_b;
    next_b_tim_en = mode.single_mode & mode.fg_cal
      & SAMPLE_IN.b_in_b;
    next_a_ofs_en = 1'b0;
    next_sel = ATTO_SEL_DUAL_A;
    case ({mode.single_mode, SAMPLE_IN.a_in_b})
      2'b00: begin
        next_sel = ATTO_SEL_DUAL_A;
        next_a_ofs_en = mode.fg_cal;
      end
      2'b01: begin
        next_sel = ATTO_SEL_DUAL_B;
        next_a_ofs_en = mode.fg_cal;
      end
      2'b10: begin
        next_sel = ATTO_SEL_SGL_A;
        next_a_ofs_en = mode.fg_cal;
      end
      2'b11: begin
        next_sel = ATTO_SEL_SGL_B;
        next_a_ofs_en = mode.fg_cal & SAMPLE_IN.a_phase90;
      end
      default: begin
        next_sel = ATTO_SEL_DUAL_A;
        next_a_ofs_en = 1'b0;
      end
    endcase
  end

  // Registered trim outputs; a deselected trim drives zero and only
  // its enable tells the core, so the stored value is never disturbed
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      TRIM_OUT <= '0;
      sel_q <= ATTO_SEL_DUAL_A;
    end else begin
      sel_q <= next_sel;
      TRIM_OUT.a_tim_en <= next_a_tim_en;
      TRIM_OUT.b_tim_en <= next_b_tim_en;
      TRIM_OUT.a_ofs_en <= next_a_ofs_en;
      TRIM_OUT.a_tim <= next_a_tim_en
        ? trim_q[ATTO_SLOT_A_SGL_B_TIM][7:0] : 8'h00;
      TRIM_OUT.b_tim <= next_b_tim_en
        ? trim_q[ATTO_SLOT_B_SGL_B_TIM][7:0] : 8'h00;
      if (!next_a_ofs_en) begin
        TRIM_OUT.a_ofs <= 12'h000;
      end else begin
        case (next_sel)
          ATTO_SEL_DUAL_A: begin
            TRIM_OUT.a_ofs <= trim_q[ATTO_SLOT_A_DUAL_A_OFS][11:0];
          end
          ATTO_SEL_DUAL_B: begin
            TRIM_OUT.a_ofs <= trim_q[ATTO_SLOT_A_DUAL_B_OFS][11:0];
          end
          ATTO_SEL_SGL_A: begin
            TRIM_OUT.a_ofs <= trim_q[ATTO_SLOT_A_SGL_A_OFS][11:0];
          end
          ATTO_SEL_SGL_B: begin
            TRIM_OUT.a_ofs <= trim_q[ATTO_SLOT_A_SGL_B_OFS][11:0];
          end
          default: begin
            TRIM_OUT.a_ofs <= 12'h000;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: bench/atto_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the trim register bank
module atto_regs_properties
  import atto_pkg::*;
(
  input wire logic MCLK_IN, // Core clock
  input wire logic RESET_IN, // Async reset
  input wire logic PSEL_IN, // Select
  input wire logic PENABLE_IN, // Enable
  input wire logic PWRITE_IN, // Direction
  input wire logic [11:0] PADDR_IN, // Byte address
  input wire logic [31:0] PRDATA_OUT, // Read data
  input wire logic PREADY_OUT, // Ready
  input wire logic PSLVERR_OUT, // Error
  input wire atto_sample_t SAMPLE_IN, // Sampling state
  input wire atto_trim_out_t TRIM_OUT // Applied trims
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  logic acc;
  // Access phase of a transfer
  assign acc = PSEL_IN && PENABLE_IN;
  ready_zero_wait_a: assert property (PREADY_OUT == acc)
    else $error("ready differs from access phase");
  err_in_access_a: assert property (PSLVERR_OUT |-> acc)
    else $error("error outside access phase");
  misalign_err_a: assert property ((PSEL_IN && !PENABLE_IN &&
    PADDR_IN[1:0] != 2'h0) ##1 acc |-> PSLVERR_OUT)
    else $error("misaligned access not refused");
  err_read_zero_a: assert property (
    PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0)
    else $error("refused read returned data");
  upper_read_zero_a: assert property (
    acc && !PWRITE_IN |-> PRDATA_OUT[31:16] == 16'h0)
    else $error("upper half of read not zero");
  tim_width_a: assert property (acc && !PWRITE_IN &&
    PADDR_IN[11:3] == 9'h18D |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("timing trim wider than eight bits");
  a_tim_cause_a: assert property (
    TRIM_OUT.a_tim_en |-> $past(SAMPLE_IN.a_in_b))
    else $error("core A timing trim without second input");
  b_tim_cause_a: assert property (
    TRIM_OUT.b_tim_en |-> $past(SAMPLE_IN.b_in_b))
    else $error("core B timing trim without second input");
  idle_trim_zero_a: assert property (
    (TRIM_OUT.a_tim_en || TRIM_OUT.a_tim == 8'h0) &&
    (TRIM_OUT.b_tim_en || TRIM_OUT.b_tim == 8'h0) &&
    (TRIM_OUT.a_ofs_en || TRIM_OUT.a_ofs == 12'h0))
    else $error("disabled trim drives a value");
  rst_clear_a: assert property (
    $past(RESET_IN) |-> TRIM_OUT == '0 && PRDATA_OUT == 32'h0)
    else $error("outputs not clear after reset");
  // Main scenarios reached
  c_a_tim: cover property (TRIM_OUT.a_tim_en);
  c_b_tim: cover property (TRIM_OUT.b_tim_en && TRIM_OUT.a_ofs_en);
  c_err: cover property (PSLVERR_OUT && PWRITE_IN);
endmodule
bind atto_regs atto_regs_properties atto_regs_properties_i (
  .MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .SAMPLE_IN(SAMPLE_IN), .TRIM_OUT(TRIM_OUT));
`default_nettype wire

// file: bench/atto_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module atto_regs_tb_top
  import atto_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic fvalid = 1'b0;
  atto_fuse_t fdata = '{8'h5A, 8'hA5, 12'h123, 12'h456, 12'h789, 12'hABC};
  atto_sample_t samp = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  atto_trim_out_t trim;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] ev [6];
  logic [11:0] ra [6];
  logic [31:0] rd = 32'h0;
  logic er;

  atto_regs atto_regs_i (.MCLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FUSE_VALID_IN(fvalid),
    .FUSE_DATA_IN(fdata), .SAMPLE_IN(samp), .TRIM_OUT(trim));

  // 100 MHz clock
  always #5 clk = ~clk;

  // One bus transfer; the slave sets the pace, a bound cuts a hang
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) err_total++;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Defaults come from fuses after reset clears everything
  task automatic t_fuse;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0, 4'h0);
      chk(rd, 32'h0);
    end
    fvalid <= 1'b1;
    for (int n = 0; n < 10 && rd[ATTO_ST_LOADED_BIT] !== 1'b1; n++) begin
      apb(1'b0, {ATTO_IDX_STATUS, 2'b00}, 32'h0, 4'h0);
    end
    chk(rd, 32'h1);
    ev = '{32'h5A, 32'hA5, 32'h123, 32'h456, 32'h789, 32'hABC};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0, 4'h0);
      chk(rd, ev[i]);
    end
  endtask

  // Overwrite all, reserved nibble included, then one lane only
  task automatic t_rw;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ra[i], 32'hFFFF_E0F0 + i, 4'hF);
      ev[i] = (32'hE0F0 + i) & (i < 2 ? 32'hFF : 32'hFFFF);
      apb(1'b0, ra[i], 32'h0, 4'h0);
      chk(rd, ev[i]);
    end
    apb(1'b1, ra[2], 32'h0000_3344, 4'h1);
    ev[2] = {ev[2][31:8], 8'h44};
    apb(1'b0, ra[2], 32'h0, 4'h0);
    chk(rd, ev[2]);
  endtask

  // Misaligned write is refused and leaves the trim alone
  task automatic t_err;
    apb(1'b1, ra[3] + 12'h2, 32'h0, 4'hF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, ra[3], 32'h0, 4'h0);
    chk(rd, ev[3]);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask

  // Reload request restores every overwritten trim to its fuse default
  task automatic t_reload;
    apb(1'b1, {ATTO_IDX_CTRL, 2'b00}, 32'h4, 4'h1);
    ev = '{32'h5A, 32'hA5, 32'h123, 32'h456, 32'h789, 32'hABC};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0, 4'h0);
      chk(rd, ev[i]);
    end
  endtask

  // Every mode, calibration and core A input combination; b_in_b always follows !a_phase90
  task automatic t_sel;
    atto_trim_out_t et;
    logic s, f, ab, ph;
    for (int i = 0; i < 16; i++) begin
      {f, s, ab, ph} = i[3:0];
      apb(1'b1, {ATTO_IDX_CTRL, 2'b00}, {30'h0, f, s}, 4'hF);
      samp <= '{ab, ph, !ph};
      repeat (3) @(posedge clk);
      et.a_tim_en = s & f & ab;
      et.a_tim = et.a_tim_en ? ev[0][7:0] : 8'h0;
      et.b_tim_en = s & f & !ph;
      et.b_tim = et.b_tim_en ? ev[1][7:0] : 8'h0;
      et.a_ofs_en = f & (!(s & ab) | ph);
      et.a_ofs = et.a_ofs_en ? ev[2 + 2 * s + ab][11:0] : 12'h0;
      chk({1'b0, trim}, {1'b0, et});
      chk(32'(trim.a_ofs), 32'(et.a_ofs));
    end
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 6; i++) ra[i] = {ATTO_TRIM_IDX[i], 2'b00};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_fuse;
    t_rw;
    t_err;
    t_reload;
    t_sel;
    conclude;
  end

  // Watchdog, far beyond the few hundred cycles expected
  initial begin
    #50us;
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
